// ### rtl/flpf_regs.svh
// constants for the fault log preamble framer
`ifndef FLPF_REGS_SVH
`define FLPF_REGS_SVH
`define FLPF_BYTE_PTR 7'h00
`define FLPF_BYTE_TS_FIRST 7'h01
`define FLPF_BYTE_TS_LAST 7'h06
`define FLPF_BYTE_CH0 7'h07
`define FLPF_BYTE_INPUT 7'h13
`define FLPF_BYTE_CH1 7'h1f
`define FLPF_BYTE_STATUS 7'h43
`define FLPF_BYTE_LAST 7'h4e
`define FLPF_RECORD_LAST 8'hfe
`define FLPF_TICK_US 200
`define FLPF_CLK_NS 100
`define FLPF_TICK_CYC ((`FLPF_TICK_US * 1000) / `FLPF_CLK_NS)
`endif

// ### rtl/flpf_pkg.sv
// types of the fault log preamble framer
package flpf_pkg;
   typedef enum logic [1:0] {
      FLPF_IDLE = 2'b00,
      FLPF_PRE = 2'b01,
      FLPF_TAIL = 2'b11
   } flpf_state_t;
endpackage

// ### rtl/flpf_time_stamp.sv
// shared time stamp counter ticking every 200 us
`include "flpf_regs.svh"
module flpf_time_stamp #(
   parameter int TICK_CYC = `FLPF_TICK_CYC,
   parameter int TS_W = 41
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // counter value
   output logic [TS_W-1:0] o_stamp
);
   logic [31:0] div_r;
   logic [31:0] div_nxt;
   logic [TS_W-1:0] stamp_r;
   logic [TS_W-1:0] stamp_nxt;

   // refuse a divider or width that cannot count
   if (TICK_CYC < 1 || TS_W < 1)
   begin : g_bad_param
      $error("flpf_time_stamp: bad parameters");
   end

   // divider and stamp advance
   always_comb
   begin
      div_nxt = div_r + 32'h0000_0001;
      stamp_nxt = stamp_r;
      if (div_r == 32'(TICK_CYC - 1))
      begin
         div_nxt = 32'h0000_0000;
         stamp_nxt = stamp_r + {{(TS_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         div_r <= 32'h0000_0000;
         stamp_r <= '0;
      end
      else
      begin
         div_r <= div_nxt;
         stamp_r <= stamp_nxt;
      end
   end

   assign o_stamp = stamp_r;
endmodule

// ### rtl/flpf_framer.sv
// fault log record framer: snapshot and byte stream of the preamble
`include "flpf_regs.svh"
module flpf_framer
   import flpf_pkg::*;
#(
   parameter int NCH = 4,
   parameter int TICK_CYC = `FLPF_TICK_CYC
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // capture side
   input wire logic i_capture,
   input wire logic [7:0] i_ptr,
   input wire logic [NCH*16-1:0] i_vout_peak,
   input wire logic [NCH*16-1:0] i_vout_min,
   input wire logic [NCH*16-1:0] i_temp_peak,
   input wire logic [NCH*16-1:0] i_temp_min,
   input wire logic [NCH*16-1:0] i_iout_peak,
   input wire logic [NCH*16-1:0] i_iout_min,
   input wire logic [15:0] i_vin_peak,
   input wire logic [15:0] i_vin_min,
   input wire logic [15:0] i_iin_peak,
   input wire logic [15:0] i_iin_min,
   input wire logic [15:0] i_pin_peak,
   input wire logic [15:0] i_pin_min,
   input wire logic [NCH*8-1:0] i_stat_vout,
   input wire logic [NCH*8-1:0] i_stat_iout,
   input wire logic [NCH*8-1:0] i_stat_mfr,
   // host read side
   input wire logic i_rd_start,
   input wire logic i_rd_next,
   input wire logic [7:0] i_tail_data,
   // byte stream out
   output logic o_valid,
   output logic [7:0] o_data,
   output logic [7:0] o_index,
   output logic o_tail,
   output logic o_last,
   output logic o_captured
);
   localparam int PRE_BYTES = 79;

   logic [40:0] stamp;
   logic [7:0] snap_r [PRE_BYTES];
   logic [7:0] snap_nxt [PRE_BYTES];
   logic [7:0] live [PRE_BYTES];
   flpf_state_t state_r;
   flpf_state_t state_nxt;
   logic [7:0] idx_r;
   logic [7:0] idx_nxt;
   logic valid_r;
   logic valid_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   logic [7:0] oidx_r;
   logic [7:0] oidx_nxt;
   logic tail_r;
   logic tail_nxt;
   logic last_r;
   logic last_nxt;
   logic capd_r;
   logic capd_nxt;

   // the byte layout below serves exactly four channels
   if (NCH != 4)
   begin : g_bad_nch
      $error("flpf_framer: preamble layout serves four channels only");
   end

   flpf_time_stamp #(
      .TICK_CYC(TICK_CYC),
      .TS_W(41)
   ) u_stamp (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .o_stamp(stamp)
   );

   // fixed fields of the live preamble image
   assign live[0] = i_ptr;
   assign live[1] = stamp[7:0];
   assign live[2] = stamp[15:8];
   assign live[3] = stamp[23:16];
   assign live[4] = stamp[31:24];
   assign live[5] = stamp[39:32];
   assign live[6] = {7'h00, stamp[40]};
   assign live[19] = i_vin_peak[7:0];
   assign live[20] = i_vin_peak[15:8];
   assign live[21] = i_vin_min[7:0];
   assign live[22] = i_vin_min[15:8];
   assign live[23] = i_iin_peak[7:0];
   assign live[24] = i_iin_peak[15:8];
   assign live[25] = i_iin_min[7:0];
   assign live[26] = i_iin_min[15:8];
   assign live[27] = i_pin_peak[7:0];
   assign live[28] = i_pin_peak[15:8];
   assign live[29] = i_pin_min[7:0];
   assign live[30] = i_pin_min[15:8];

   // per-channel groups and status bytes
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      localparam int B = (c == 0) ? `FLPF_BYTE_CH0 : `FLPF_BYTE_CH1 + (c - 1) * 12;
      localparam int S = `FLPF_BYTE_STATUS + c * 3;
      logic [15:0] vals [6];
      assign vals[0] = i_vout_peak[c*16 +: 16];
      assign vals[1] = i_vout_min[c*16 +: 16];
      assign vals[2] = i_temp_peak[c*16 +: 16];
      assign vals[3] = i_temp_min[c*16 +: 16];
      assign vals[4] = i_iout_peak[c*16 +: 16];
      assign vals[5] = i_iout_min[c*16 +: 16];
      for (genvar k = 0; k < 6; k++)
      begin : g_val
         assign live[B + 2*k] = vals[k][7:0];
         assign live[B + 2*k + 1] = vals[k][15:8];
      end
      assign live[S] = i_stat_vout[c*8 +: 8];
      assign live[S + 1] = i_stat_iout[c*8 +: 8];
      assign live[S + 2] = i_stat_mfr[c*8 +: 8];
   end

   // snapshot taken whole on capture
   always_comb
   begin
      snap_nxt = snap_r;
      capd_nxt = capd_r;
      if (i_capture)
      begin
         snap_nxt = live;
         capd_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         for (int i = 0; i < PRE_BYTES; i++)
         begin
            snap_r[i] <= 8'h00;
         end
         capd_r <= 1'b0;
      end
      else
      begin
         snap_r <= snap_nxt;
         capd_r <= capd_nxt;
      end
   end

   // read sequencer: one byte per request, ascending
   always_comb
   begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      valid_nxt = 1'b0;
      data_nxt = data_r;
      oidx_nxt = oidx_r;
      tail_nxt = tail_r;
      last_nxt = last_r;
      if (i_rd_start)
      begin
         state_nxt = FLPF_PRE;
         idx_nxt = 8'h00;
      end
      else if (i_rd_next && state_r != FLPF_IDLE)
      begin
         valid_nxt = 1'b1;
         oidx_nxt = idx_r;
         last_nxt = (idx_r == `FLPF_RECORD_LAST);
         // preamble bytes from the snapshot, the rest passed through
         case (state_r)
            FLPF_PRE:
            begin
               data_nxt = snap_r[idx_r[6:0]];
               tail_nxt = 1'b0;
            end
            default:
            begin
               data_nxt = i_tail_data;
               tail_nxt = 1'b1;
            end
         endcase
         idx_nxt = idx_r + 8'h01;
         if (idx_r == {1'b0, `FLPF_BYTE_LAST})
         begin
            state_nxt = FLPF_TAIL;
         end
         if (idx_r == `FLPF_RECORD_LAST)
         begin
            state_nxt = FLPF_IDLE;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_r <= FLPF_IDLE;
         idx_r <= 8'h00;
         valid_r <= 1'b0;
         data_r <= 8'h00;
         oidx_r <= 8'h00;
         tail_r <= 1'b0;
         last_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         valid_r <= valid_nxt;
         data_r <= data_nxt;
         oidx_r <= oidx_nxt;
         tail_r <= tail_nxt;
         last_r <= last_nxt;
      end
   end

   assign o_valid = valid_r;
   assign o_data = data_r;
   assign o_index = oidx_r;
   assign o_tail = tail_r;
   assign o_last = last_r;
   assign o_captured = capd_r;
endmodule

// ### verification/flpf_framer_props.sv
// checker for the framer's read and capture ports
module flpf_framer_props (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // capture and read requests
   input wire logic i_capture,
   input wire logic [7:0] i_ptr,
   input wire logic i_rd_start,
   input wire logic i_rd_next,
   input wire logic [7:0] i_tail_data,
   // byte stream
   input wire logic o_valid,
   input wire logic [7:0] o_data,
   input wire logic [7:0] o_index,
   input wire logic o_tail,
   input wire logic o_last,
   input wire logic o_captured
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ptr_r;
   // pointer as held by the latest capture
   always_ff @(posedge i_sys_clk)
   begin
      ptr_r <= i_srst ? 8'h00 : (i_capture ? i_ptr : ptr_r);
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   chk_first_index: assert property (i_rd_start ##1 (i_rd_next && !i_rd_start) |=> o_valid && o_index == 8'h00)
      else $error("read did not begin at index 0");
   chk_index_step: assert property (o_valid && !o_last && i_rd_next && !i_rd_start |=> o_valid && o_index == $past(o_index) + 8'h01)
      else $error("index did not step by one");
   chk_last_flag: assert property (o_valid |-> o_last == (o_index == 8'hfe))
      else $error("last flag wrong");
   chk_tail_flag: assert property (o_valid |-> o_tail == (o_index > 8'h4e))
      else $error("tail flag wrong");
   chk_tail_pass: assert property (o_valid && o_tail |-> o_data == $past(i_tail_data))
      else $error("tail byte not passed through");
   chk_stop_after: assert property (o_valid && o_last && !i_rd_start |=> !o_valid)
      else $error("byte after the last one");
   chk_ptr_byte: assert property (o_valid && o_index == 8'h00 |-> o_data == ptr_r)
      else $error("byte 0 is not the captured pointer");
   chk_cap_flag: assert property (i_capture |=> o_captured [*2])
      else $error("capture flag not held");
endmodule

// ### verification/flpf_host_model.sv
// host model issuing block reads and feeding tail bytes
module flpf_host_model (
   // clock and byte stream from the framer
   input wire logic i_sys_clk,
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   input wire logic [7:0] i_index,
   // requests and tail bytes to the framer
   output logic o_start,
   output logic o_next,
   output logic [7:0] o_tail
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got [0:254];
   initial
   begin
      o_start = 1'b0;
      o_next = 1'b0;
      o_tail = 8'h00;
   end
   // bytes kept by index as they arrive
   always @(posedge i_sys_clk)
   begin
      if (i_valid) got[i_index] <= i_data;
   end
   // optional start, then n requests with gap idle cycles between
   task automatic rd(input bit st, input int n, input int gap);
      if (st)
      begin
         @(posedge i_sys_clk) #1 o_start = 1'b1;
         @(posedge i_sys_clk) #1 o_start = 1'b0;
      end
      for (int i = 0; i < n; i++)
      begin
         o_next = 1'b1;
         o_tail = 8'(i) ^ 8'h5a;
         @(posedge i_sys_clk) #1;
         if (gap > 0 || i == n - 1)
         begin
            o_next = 1'b0;
            o_tail = ~o_tail; // released, so no longer the last value
            repeat (gap) @(posedge i_sys_clk) #1;
         end
      end
      repeat (2) @(posedge i_sys_clk) #1;
   endtask
endmodule

// ### verification/flpf_framer_tb.sv
// self-checking bench for the preamble framer
module flpf_framer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TICK = 4;
   logic clk = 1'b0, srst = 1'b1, cap = 1'b0, st, nx, vld, tl, lst, capd;
   logic [7:0] ptr = 8'h00, td, dat, idx;
   logic [63:0] vp = '0, vm = '0, tp = '0, tm = '0, ip = '0, im = '0;
   logic [15:0] vip = '0, vim = '0, iip = '0, iim = '0, pip = '0, pim = '0;
   logic [31:0] sv = '0, si = '0, sm = '0;
   logic [7:0] exp [0:78];
   int err_count = 0, comparisons = 0, cyc = 0, nval = 0, n0;
   flpf_framer #(.NCH(4), .TICK_CYC(TICK)) dut (.i_sys_clk(clk), .i_srst(srst), .i_capture(cap),
      .i_ptr(ptr), .i_vout_peak(vp), .i_vout_min(vm), .i_temp_peak(tp), .i_temp_min(tm),
      .i_iout_peak(ip), .i_iout_min(im), .i_vin_peak(vip), .i_vin_min(vim), .i_iin_peak(iip),
      .i_iin_min(iim), .i_pin_peak(pip), .i_pin_min(pim), .i_stat_vout(sv), .i_stat_iout(si),
      .i_stat_mfr(sm), .i_rd_start(st), .i_rd_next(nx), .i_tail_data(td), .o_valid(vld),
      .o_data(dat), .o_index(idx), .o_tail(tl), .o_last(lst), .o_captured(capd));
   flpf_host_model host (.i_sys_clk(clk), .i_valid(vld), .i_data(dat), .i_index(idx),
      .o_start(st), .o_next(nx), .o_tail(td));
   always #50 clk = ~clk;
   // cycle and answer counters
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      nval <= nval + int'(vld);
   end
   task check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want)
      begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task results;
      $display("%0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task capture;
      @(posedge clk) #1 cap = 1'b1;
      @(posedge clk) #1 cap = 1'b0;
   endtask
   // full record, with inputs changed after the capture
   task t_record;
      int g;
      for (int b = 7; b < 79; b++) exp[b] = 8'(b * 7 + 3);
      exp[0] = 8'hc5;
      ptr = exp[0];
      for (int c = 0; c < 4; c++)
      begin
         g = (c == 0) ? 7 : 19 + 12 * c;
         vp[c*16+:16] = {exp[g+1], exp[g]};
         vm[c*16+:16] = {exp[g+3], exp[g+2]};
         tp[c*16+:16] = {exp[g+5], exp[g+4]};
         tm[c*16+:16] = {exp[g+7], exp[g+6]};
         ip[c*16+:16] = {exp[g+9], exp[g+8]};
         im[c*16+:16] = {exp[g+11], exp[g+10]};
         {sv[c*8+:8], si[c*8+:8], sm[c*8+:8]} = {exp[67+3*c], exp[68+3*c], exp[69+3*c]};
      end
      {vip, vim, iip, iim} = {exp[20], exp[19], exp[22], exp[21], exp[24], exp[23], exp[26], exp[25]};
      {pip, pim} = {exp[28], exp[27], exp[30], exp[29]};
      capture;
      {ptr, vp, sv} = {8'h3a, ~vp, ~sv};
      n0 = nval;
      host.rd(1, 255, 0);
      host.rd(0, 1, 0);
      check(8'(nval - n0), 8'hff);
      check(8'(capd), 8'h01);
      check(idx, 8'hfe);
      check({6'h00, tl, lst}, 8'h03);
      check(host.got[0], exp[0]);
      for (int b = 1; b < 255; b++)
         check(host.got[b], b < 7 ? 8'h00 : (b < 79 ? exp[b] : 8'(b) ^ 8'h5a));
      $display("record test done");
   endtask
   // two captures a known number of ticks apart, slow reads
   task t_stamp;
      int c0;
      logic [7:0] s0;
      capture;
      c0 = cyc;
      host.rd(1, 2, 3);
      s0 = host.got[1];
      while (cyc < c0 + 40 * TICK - 2) @(posedge clk) #1;
      capture;
      host.rd(1, 7, 3);
      check(host.got[1] - s0, 8'h28);
      for (int b = 2; b < 7; b++)
         check(host.got[b], 8'h00);
      $display("stamp test done");
   endtask
   // reset mid-run, stray request, restart mid-read
   task t_reset;
      @(posedge clk) #1 srst = 1'b1;
      @(posedge clk) #1 srst = 1'b0;
      check(8'(capd), 8'h00);
      n0 = nval;
      host.rd(0, 1, 0);
      check(8'(nval - n0), 8'h00);
      host.rd(1, 3, 0);
      host.rd(1, 1, 2);
      check(idx, 8'h00);
      check(dat, 8'h00);
      $display("reset test done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      t_record;
      t_stamp;
      t_reset;
      results;
   end
   initial
   begin
      #1_000_000;
      err_count++;
      results;
   end
endmodule
bind flpf_framer flpf_framer_props chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
   .i_capture(i_capture), .i_ptr(i_ptr), .i_rd_start(i_rd_start), .i_rd_next(i_rd_next),
   .i_tail_data(i_tail_data), .o_valid(o_valid), .o_data(o_data), .o_index(o_index),
   .o_tail(o_tail), .o_last(o_last), .o_captured(o_captured));
